// ==== verilog/port_mux_pkg.sv ====
// constants shared by the port mux, its controller and the link between them
// assumes a 16-bit register view of every port control register
package port_mux_pkg;
  localparam int SEL_W = 4;
  // register select codes on the link
  localparam logic [3:0] SEL_P6_DATA = 4'h0;
  localparam logic [3:0] SEL_P6_DIR = 4'h1;
  localparam logic [3:0] SEL_P6_CTRL = 4'h2;
  localparam logic [3:0] SEL_P6_FUNC = 4'h3;
  localparam logic [3:0] SEL_P6_PULL = 4'h4;
  localparam logic [3:0] SEL_P9_DATA = 4'h5;
  localparam logic [3:0] SEL_P9_DIR = 4'h6;
  localparam logic [3:0] SEL_P9_CTRL = 4'h7;
  localparam logic [3:0] SEL_P9_FUNC = 4'h8;
  localparam logic [3:0] SEL_P9_EXT = 4'h9;
  localparam logic [3:0] SEL_P7_DIR = 4'ha;
  localparam logic [3:0] SEL_KEY_MODE = 4'hb;
  localparam logic [3:0] SEL_IRQ14_EDGE = 4'hc;
  localparam logic [3:0] SEL_SER3_CTRL = 4'hd;
  localparam logic [3:0] SEL_P7_DATA = 4'he;
  localparam int REG_N = 14;
  // access size on the link
  typedef enum logic [1:0] {SIZE_16, SIZE_8, SIZE_1} size_t;
  // bit positions inside small control registers
  localparam int IRQ14_RISE_BIT = 0;
  localparam int IRQ14_FALL_BIT = 1;
  localparam int SER3_RXE_BIT = 0;
  localparam int SHARED_PINS = 4;
  // reset values
  localparam logic [15:0] DIR_RESET = 16'hffff;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // controller register byte addresses and command fields
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam int CMD_SEL_LSB = 0;
  localparam int CMD_HIGH_BIT = 4;
  localparam int CMD_SIZE_LSB = 5;
  localparam int CMD_BIT_LSB = 8;
  localparam int CMD_WE_BIT = 11;
  localparam int CMD_DATA_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DATA_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verilog/port_reg_if.sv ====
// register link between the port controller and the port mux
// assumes both ends share clk_i; one access in flight at a time
`timescale 1ns/100ps
interface port_reg_if;
  logic req;
  logic we;
  logic [3:0] sel;
  logic high;
  port_mux_pkg::size_t size;
  logic [2:0] bit_idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  modport device (input req, we, sel, high, size, bit_idx, wdata, output rdata, ack);
  modport ctrl (output req, we, sel, high, size, bit_idx, wdata, input rdata, ack);
endinterface

// ==== verilog/port_alt_function_mux.sv ====
// port 6/7/9 control registers with high-byte aliases and alternate-function pin routing
// assumes pins and peripheral signals are synchronous to clk_i
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module port_alt_function_mux #(
  parameter bit HAS_SERIAL3 = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  port_reg_if.device link,
  // port 6 pins and the peripheral drive that may take them over
  input wire logic [15:0] p6_pin_i,
  output logic [15:0] p6_pin_o,
  output logic [15:0] p6_oe_o,
  output logic [15:0] p6_pullup_o,
  input wire logic [15:0] p6_periph_o_i,
  input wire logic [15:0] p6_periph_oe_i,
  // port 9 pins; bits 3:0 are also shared by key-return and timer capture
  input wire logic [15:0] p9_pin_i,
  output logic [15:0] p9_pin_o,
  output logic [15:0] p9_oe_o,
  input wire logic [15:0] p9_periph_o_i,
  input wire logic [15:0] p9_periph_oe_i,
  // port 7 pins are read only; their analog use follows the direction register
  input wire logic [15:0] p7_pin_i,
  output logic [15:0] analog_input_channel_o,
  output logic [3:0] key_return_input_o,
  output logic [3:0] timer_capture_input_o,
  // one pin shared by interrupt 14 and the serial 3 receiver
  input wire logic irq14_pin_i,
  output logic external_interrupt_14_o,
  output logic serial3_receive_input_o
);
  // r holds every writable register, indexed by its select code
  typedef struct packed {
    logic [port_mux_pkg::REG_N-1:0][15:0] r;
    logic [15:0] rdata;
    logic ack;
    logic irq14_prev;
    logic [15:0] p6_o;
    logic [15:0] p6_oe;
    logic [15:0] p9_o;
    logic [15:0] p9_oe;
    logic [15:0] analog;
    logic [3:0] key;
    logic [3:0] cap;
    logic irq14;
    logic rx;
  } state_t;

  state_t q, d;

  // merge a narrow write into a 16-bit register; alias byte and bit accesses only move the upper byte, a 16-bit access ignores the alias
  function automatic logic [15:0] merge(input logic [15:0] old, input logic high,
      input port_mux_pkg::size_t size, input logic [2:0] idx, input logic [15:0] wd);
    logic [15:0] res;
    res = old;
    case (size)
      port_mux_pkg::SIZE_16: res = wd;
      port_mux_pkg::SIZE_8: begin
        if (high) res[15:8] = wd[7:0];
        else res[7:0] = wd[7:0];
      end
      // the alias supplies bit 3 of the index, so bit accesses reach all 16 bits
      port_mux_pkg::SIZE_1: res[{high, idx}] = wd[0];
      default: res = old;
    endcase
    return res;
  endfunction

  // present the addressed byte or bit in the low bits of the answer
  function automatic logic [15:0] extract(input logic [15:0] v, input logic high,
      input port_mux_pkg::size_t size, input logic [2:0] idx);
    logic [15:0] res;
    res = 16'h0000;
    case (size)
      port_mux_pkg::SIZE_16: res = v;
      port_mux_pkg::SIZE_8: res = {8'h00, high ? v[15:8] : v[7:0]};
      port_mux_pkg::SIZE_1: res = {15'h0000, v[{high, idx}]};
      default: res = 16'h0000;
    endcase
    return res;
  endfunction

  logic [15:0] p6_view;
  logic [15:0] p9_view;
  logic [15:0] cur;
  logic [15:0] p6_dir;
  logic [15:0] p6_ctrl;
  logic [15:0] p6_func;
  logic [15:0] p9_dir;
  logic [15:0] p9_ctrl;
  logic [15:0] p9_sel;
  logic [15:0] edge_en;
  logic rise;
  logic fall;
  logic [15:0] p6_alt;
  logic [15:0] p9_alt;
  logic mapped;
  logic writable;

  assign p6_dir = q.r[port_mux_pkg::SEL_P6_DIR];
  assign p6_ctrl = q.r[port_mux_pkg::SEL_P6_CTRL];
  assign p6_func = q.r[port_mux_pkg::SEL_P6_FUNC];
  assign p9_dir = q.r[port_mux_pkg::SEL_P9_DIR];
  assign p9_ctrl = q.r[port_mux_pkg::SEL_P9_CTRL];
  // either function-select bit names a port 9 function
  assign p9_sel = q.r[port_mux_pkg::SEL_P9_FUNC] | q.r[port_mux_pkg::SEL_P9_EXT];
  assign edge_en = q.r[port_mux_pkg::SEL_IRQ14_EDGE];
  assign rise = irq14_pin_i & ~q.irq14_prev;
  assign fall = ~irq14_pin_i & q.irq14_prev;
  // a control-mode pin hands its drive to the peripheral only once a function is chosen;
  // before that it stays low and undriven instead of showing an undefined level
  assign p6_alt = p6_ctrl & p6_func;
  assign p9_alt = p9_ctrl & p9_sel;
  // selects from 14 up hold no register, and port 7 data is read-only pin state
  assign mapped = link.sel < port_mux_pkg::SEL_P7_DATA;
  assign writable = link.we & mapped;
  // input pins read back through the data register, output pins read the latch
  assign p6_view = (p6_dir & p6_pin_i) | (~p6_dir & q.r[port_mux_pkg::SEL_P6_DATA]);
  assign p9_view = (p9_dir & p9_pin_i) | (~p9_dir & q.r[port_mux_pkg::SEL_P9_DATA]);

  // one access per request: the answer is registered and stands until the next one
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.irq14_prev = irq14_pin_i;
    case (link.sel)
      port_mux_pkg::SEL_P6_DATA: cur = p6_view;
      port_mux_pkg::SEL_P9_DATA: cur = p9_view;
      // reading while a conversion runs gives whatever the pins show at that moment
      port_mux_pkg::SEL_P7_DATA: cur = p7_pin_i;
      port_mux_pkg::SEL_SER3_CTRL: cur = HAS_SERIAL3 ? q.r[link.sel] : 16'h0000;
      default: cur = mapped ? q.r[link.sel] : 16'h0000;
    endcase
    // refused selects are still answered so the controller never stalls on them
    if (link.req) begin
      d.ack = 1'b1;
      d.rdata = extract(cur, link.high, link.size, link.bit_idx);
      if (writable) begin
        d.r[link.sel] = merge(q.r[link.sel], link.high, link.size, link.bit_idx,
            link.wdata);
      end
    end
    // unselected control function outputs low with its enable off rather than garbage
    // in port mode the latch drives and a set direction bit means input
    d.p6_o = (p6_alt & p6_periph_o_i) |
        (~p6_ctrl & q.r[port_mux_pkg::SEL_P6_DATA]);
    d.p6_oe = (p6_alt & p6_periph_oe_i) |
        (~p6_ctrl & ~p6_dir);
    d.p9_o = (p9_alt & p9_periph_o_i) |
        (~p9_ctrl & q.r[port_mux_pkg::SEL_P9_DATA]);
    d.p9_oe = (p9_alt & p9_periph_oe_i) |
        (~p9_ctrl & ~p9_dir);
    // the converter has no enable here: every input-mode pin is offered to it
    d.analog = q.r[port_mux_pkg::SEL_P7_DIR];
    // both functions see the shared pin; software keeps only one enabled
    d.key = p9_pin_i[port_mux_pkg::SHARED_PINS-1:0] &
        q.r[port_mux_pkg::SEL_KEY_MODE][port_mux_pkg::SHARED_PINS-1:0];
    d.cap = p9_pin_i[port_mux_pkg::SHARED_PINS-1:0] &
        p9_ctrl[port_mux_pkg::SHARED_PINS-1:0];
    // the pulse is registered on the same clock as the sample that shows the edge and lasts one clock
    d.irq14 = (rise & edge_en[port_mux_pkg::IRQ14_RISE_BIT]) |
        (fall & edge_en[port_mux_pkg::IRQ14_FALL_BIT]);
    // a stopped or absent receiver sees an idle line, never a false start bit
    d.rx = 1'b1;
    if (HAS_SERIAL3 && q.r[port_mux_pkg::SEL_SER3_CTRL][port_mux_pkg::SER3_RXE_BIT]) begin
      d.rx = irq14_pin_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      // directions reset to input so no pin drives before software sets it up
      q <= '0;
      q.r[port_mux_pkg::SEL_P6_DIR] <= port_mux_pkg::DIR_RESET;
      q.r[port_mux_pkg::SEL_P9_DIR] <= port_mux_pkg::DIR_RESET;
      q.r[port_mux_pkg::SEL_P7_DIR] <= port_mux_pkg::DIR_RESET;
      q.rx <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign link.rdata = q.rdata;
  assign link.ack = q.ack;
  assign p6_pin_o = q.p6_o;
  assign p6_oe_o = q.p6_oe;
  assign p6_pullup_o = q.r[port_mux_pkg::SEL_P6_PULL];
  assign p9_pin_o = q.p9_o;
  assign p9_oe_o = q.p9_oe;
  assign analog_input_channel_o = q.analog;
  assign key_return_input_o = q.key;
  assign timer_capture_input_o = q.cap;
  assign external_interrupt_14_o = q.irq14;
  assign serial3_receive_input_o = q.rx;
endmodule // port_alt_function_mux

// ==== verilog/port_mux_ctrl.sv ====
// software-facing controller: AXI4-Lite slave that issues accesses on the port link
// assumes one AXI write and one read at most in flight
`timescale 1ns/100ps
module port_mux_ctrl (
  input wire logic clk_i,
  input wire logic reset_i,
  port_reg_if.ctrl link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef struct packed {
    logic aw_got;
    logic [3:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic busy;
    logic req;
    logic [31:0] cmd;
    logic [15:0] result;
  } state_t;

  state_t q, d;
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;

  assign aw_rdy = ~q.aw_got & ~q.bvalid;
  assign w_rdy = ~q.w_got & ~q.bvalid;
  assign ar_rdy = ~q.rvalid;

  always_comb begin
    d = q;
    d.req = 1'b0;
    if (s_axi_awvalid && aw_rdy) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && w_rdy) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = port_mux_pkg::RESP_OKAY;
      if (q.awaddr == port_mux_pkg::ADDR_CMD) begin
        // a command written while one is running is dropped, not queued
        if (!q.busy && q.wstrb == 4'hf) begin
          d.cmd = q.wdata;
          d.busy = 1'b1;
          d.req = 1'b1;
        end
      end else if (q.awaddr != port_mux_pkg::ADDR_STATUS) begin
        d.bresp = port_mux_pkg::RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (link.ack) begin
      d.busy = 1'b0;
      d.result = link.rdata;
    end
    if (s_axi_arvalid && ar_rdy) begin
      d.rvalid = 1'b1;
      d.rresp = port_mux_pkg::RESP_OKAY;
      case (s_axi_araddr)
        port_mux_pkg::ADDR_CMD: d.rdata = q.cmd;
        port_mux_pkg::ADDR_STATUS: d.rdata = {q.result, 15'h0000, q.busy};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = port_mux_pkg::RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) q <= '0;
    else q <= d;
  end

  assign s_axi_awready = aw_rdy;
  assign s_axi_wready = w_rdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign link.req = q.req;
  assign link.we = q.cmd[port_mux_pkg::CMD_WE_BIT];
  assign link.sel = q.cmd[port_mux_pkg::CMD_SEL_LSB +: port_mux_pkg::SEL_W];
  assign link.high = q.cmd[port_mux_pkg::CMD_HIGH_BIT];
  assign link.size = port_mux_pkg::size_t'(q.cmd[port_mux_pkg::CMD_SIZE_LSB +: 2]);
  assign link.bit_idx = q.cmd[port_mux_pkg::CMD_BIT_LSB +: 3];
  assign link.wdata = q.cmd[port_mux_pkg::CMD_DATA_LSB +: 16];
endmodule // port_mux_ctrl

// ==== tb/port_link_checker.sv ====
// assertions on the register link between controller and port mux
// assumes it is instantiated beside the link with every signal connected by name
`timescale 1ns/100ps
module port_link_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] sel,
  input wire logic high,
  input wire port_mux_pkg::size_t size,
  input wire logic [2:0] bit_idx,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  sequence s_rd8;
    req && !we && size == port_mux_pkg::SIZE_8;
  endsequence
  sequence s_rd1;
    req && !we && size == port_mux_pkg::SIZE_1;
  endsequence
  a_ack_after_req: assert property (req |=> s_answer)
    else $error("request not answered by a single ack");
  a_ack_needs_req: assert property (!req |=> !ack)
    else $error("ack without request");
  a_req_single: assert property (req |=> !req)
    else $error("request longer than one cycle");
  a_rdata_holds: assert property (!req |=> $stable(rdata))
    else $error("read data moved without an access");
  a_byte_zero_ext: assert property (s_rd8 |=> rdata[15:8] == 8'h00)
    else $error("byte read not aligned low");
  a_bit_zero_ext: assert property (s_rd1 |=> rdata[15:1] == 15'h0000)
    else $error("bit read not in bit zero");
  a_unmapped_zero: assert property (req && !we && sel == 4'hf |=> rdata == 16'h0000)
    else $error("unmapped select read not zero");
  a_fields_held: assert property (req |=> $stable({we, sel, high, size, bit_idx, wdata}))
    else $error("access fields changed after request");
endmodule // port_link_checker

// ==== tb/testbench.sv ====
// self-checking bench: AXI4-Lite controller and port mux joined by the link
// assumes package and interface are compiled first; one access at a time
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq = 1'b0, ext14, rx;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] p6_pin = 16'h0000, p6_po = 16'h0000, p6_poe = 16'h0000, p9_pin = 16'h0000;
  logic [15:0] p9_po = 16'h0000, p9_poe = 16'hffff, p7_pin = 16'h0000;
  logic [15:0] p6o, p6oe, p6pu, p9o, p9oe, ana;
  logic [3:0] kr, tc;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  port_reg_if link ();
  port_mux_ctrl i_port_mux_ctrl (.clk_i, .reset_i, .link(link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  port_alt_function_mux #(.HAS_SERIAL3(1'b1)) i_port_alt_function_mux (.clk_i, .reset_i,
    .link(link), .p6_pin_i(p6_pin), .p6_pin_o(p6o), .p6_oe_o(p6oe), .p6_pullup_o(p6pu),
    .p6_periph_o_i(p6_po), .p6_periph_oe_i(p6_poe), .p9_pin_i(p9_pin), .p9_pin_o(p9o),
    .p9_oe_o(p9oe), .p9_periph_o_i(p9_po), .p9_periph_oe_i(p9_poe), .p7_pin_i(p7_pin),
    .analog_input_channel_o(ana), .key_return_input_o(kr), .timer_capture_input_o(tc),
    .irq14_pin_i(irq), .external_interrupt_14_o(ext14), .serial3_receive_input_o(rx));
  port_link_checker i_port_link_checker (.clk_i, .reset_i, .req(link.req), .we(link.we),
    .sel(link.sel), .high(link.high), .size(link.size), .bit_idx(link.bit_idx),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_i);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    {araddr, arvalid, rready} <= {a, 2'b11};
    rh = 1'b0;
    while (!rh) begin
      @(negedge clk_i);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk_i);
  endtask
  // one link access: command word, then poll status until the answer is back
  task automatic op(input logic [3:0] s, input logic h, input port_mux_pkg::size_t z,
    input logic [2:0] b, input logic w, input logic [15:0] d, output logic [15:0] v);
    logic [31:0] st;
    logic [1:0] r;
    axi_wr(port_mux_pkg::ADDR_CMD, {d, 4'h0, w, b, 1'b0, z, h, s}, r);
    st = 32'h0000_0001;
    while (st[0]) axi_rd(port_mux_pkg::ADDR_STATUS, st, r);
    v = st[31:16];
  endtask
  task automatic wr(input logic [3:0] s, input logic [15:0] d);
    logic [15:0] x;
    op(s, 1'b0, port_mux_pkg::SIZE_16, 3'h0, 1'b1, d, x);
  endtask
  task automatic get(input logic [3:0] s, input logic h, input port_mux_pkg::size_t z,
    input logic [2:0] b, output logic [15:0] v);
    op(s, h, z, b, 1'b0, 16'h0000, v);
  endtask
  task automatic pulses(output int n);
    n = 0;
    repeat (8) begin
      @(negedge clk_i);
      n += ext14;
    end
    @(posedge clk_i);
  endtask
  initial begin
    logic [15:0] v;
    logic [31:0] q;
    logic [1:0] r;
    int n;
    logic [3:0] regs [8];
    regs = '{port_mux_pkg::SEL_P6_DIR, port_mux_pkg::SEL_P6_CTRL, port_mux_pkg::SEL_P6_FUNC,
      port_mux_pkg::SEL_P6_PULL, port_mux_pkg::SEL_P9_DIR, port_mux_pkg::SEL_P9_CTRL,
      port_mux_pkg::SEL_P9_FUNC, port_mux_pkg::SEL_P9_EXT};
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    get(port_mux_pkg::SEL_P9_DIR, 1'b0, port_mux_pkg::SIZE_16, 3'h0, v);
    check(v, 16'hffff);
    check(ana, 16'hffff);
    check(rx, 1'b1);
    $display("reset test done");
    foreach (regs[i]) begin
      wr(regs[i], 16'h1234);
      op(regs[i], 1'b1, port_mux_pkg::SIZE_8, 3'h0, 1'b1, 16'h005a, v);
      op(regs[i], 1'b1, port_mux_pkg::SIZE_1, 3'h3, 1'b1, 16'h0000, v);
      op(regs[i], 1'b0, port_mux_pkg::SIZE_8, 3'h0, 1'b1, 16'h00c3, v);
      get(regs[i], 1'b0, port_mux_pkg::SIZE_16, 3'h0, v);
      check(v, 16'h52c3);
      get(regs[i], 1'b1, port_mux_pkg::SIZE_8, 3'h0, v);
      check(v, 16'h0052);
      get(regs[i], 1'b1, port_mux_pkg::SIZE_1, 3'h4, v);
      check(v, 16'h0001);
    end
    check(p6pu, 16'h52c3);
    $display("alias test done");
    wr(port_mux_pkg::SEL_P6_DIR, 16'h0000);
    wr(port_mux_pkg::SEL_P6_DATA, 16'h00ff);
    wr(port_mux_pkg::SEL_P6_FUNC, 16'h0000);
    wr(port_mux_pkg::SEL_P6_CTRL, 16'h0001);
    check({p6o, p6oe}, 32'h00fe_fffe);
    {p6_po, p6_poe} <= 32'h0001_0001;
    wr(port_mux_pkg::SEL_P6_FUNC, 16'h0001);
    check({p6o, p6oe}, 32'h00ff_ffff);
    {p9_pin, p9_po} <= 32'h000f_0002;
    wr(port_mux_pkg::SEL_P9_DIR, 16'h0000);
    wr(port_mux_pkg::SEL_P9_DATA, 16'h0f0f);
    wr(port_mux_pkg::SEL_P9_FUNC, 16'h0001);
    wr(port_mux_pkg::SEL_P9_EXT, 16'h0000);
    wr(port_mux_pkg::SEL_P9_CTRL, 16'h0003);
    check({p9o, p9oe}, 32'h0f0c_fffd);
    check(tc, 4'h3);
    wr(port_mux_pkg::SEL_P9_EXT, 16'h0002);
    check({p9o, p9oe}, 32'h0f0e_ffff);
    wr(port_mux_pkg::SEL_KEY_MODE, 16'h000c);
    check(kr, 4'hc);
    $display("pin test done");
    p7_pin <= 16'hbeef;
    wr(port_mux_pkg::SEL_P7_DATA, 16'h0000);
    get(port_mux_pkg::SEL_P7_DATA, 1'b0, port_mux_pkg::SIZE_16, 3'h0, v);
    check(v, 16'hbeef);
    wr(port_mux_pkg::SEL_P7_DIR, 16'h00ff);
    check(ana, 16'h00ff);
    get(4'hf, 1'b0, port_mux_pkg::SIZE_16, 3'h0, v);
    check(v, 16'h0000);
    wr(port_mux_pkg::SEL_IRQ14_EDGE, 16'h0001);
    irq <= 1'b1;
    pulses(n);
    check(n, 1);
    irq <= 1'b0;
    pulses(n);
    check(n, 0);
    wr(port_mux_pkg::SEL_IRQ14_EDGE, 16'h0002);
    irq <= 1'b1;
    pulses(n);
    check(n, 0);
    irq <= 1'b0;
    pulses(n);
    check(n, 1);
    wr(port_mux_pkg::SEL_IRQ14_EDGE, 16'h0000);
    wr(port_mux_pkg::SEL_SER3_CTRL, 16'h0001);
    get(port_mux_pkg::SEL_SER3_CTRL, 1'b0, port_mux_pkg::SIZE_16, 3'h0, v);
    check(v, 16'h0001);
    check(rx, 1'b0);
    irq <= 1'b1;
    pulses(n);
    check(n, 0);
    check(rx, 1'b1);
    $display("shared pin test done");
    axi_wr(4'h8, 32'h0000_0000, r);
    check(r, port_mux_pkg::RESP_SLVERR);
    axi_rd(4'h8, q, r);
    check(q, 32'h0000_0000);
    check(r, port_mux_pkg::RESP_SLVERR);
    $display("bus test done");
    test_done();
  end
endmodule // testbench
